// >>> lsr_pkg.sv
// Shared constants, types and helpers for the serial command and pixel input.
package lsr_pkg;
    localparam logic [3:0] LSR_UNIT_LAST = 4'h8;
    localparam logic [5:0] LSR_LEN_NONE = 6'h00;
    localparam logic [5:0] LSR_LEN_BYTE = 6'h08;
    localparam logic [5:0] LSR_LEN_IDENT = 6'h18;
    localparam logic [5:0] LSR_LEN_STATE = 6'h20;
    localparam logic [7:0] LSR_STATUS_FIRST = 8'h0a;
    localparam logic [7:0] LSR_STATUS_LAST = 8'h0f;
    localparam logic [1:0] LSR_WIN_START_HI = 2'h0;
    localparam logic [1:0] LSR_WIN_START_LO = 2'h1;
    localparam logic [1:0] LSR_WIN_END_HI = 2'h2;
    localparam logic [1:0] LSR_WIN_END_LO = 2'h3;
    localparam int LSR_COLOR_BITS = 6;
    localparam int LSR_PIXEL_BITS = 3 * LSR_COLOR_BITS;
    localparam int LSR_ADDR_BITS = 16;
    localparam logic [15:0] LSR_WIN_MIN = 16'h0000;
    localparam logic [15:0] LSR_WIN_MAX = 16'hffff;

    typedef enum logic [2:0] {
        LSR_SER_IDLE = 3'b001,
        LSR_SER_SHIFT = 3'b010,
        LSR_SER_READ = 3'b100
    } lsr_ser_state_type;

    typedef enum logic [1:0] {
        LSR_PIX_PORCH = 2'b01,
        LSR_PIX_DRAW = 2'b10
    } lsr_pix_state_type;

    function automatic logic lsr_in_range(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        lsr_in_range = (v >= lo) && (v <= hi);
    endfunction
endpackage

// >>> lsr_if.sv
// Links between the serial engine, the pixel engine and the command core.
`timescale 1ns/100ps
interface lsr_if;
    logic unit_valid;
    logic unit_dc;
    logic [7:0] unit_byte;
    logic [5:0] rd_len;
    logic [31:0] rd_word;
    logic [15:0] col_start;
    logic [15:0] col_end;
    logic [15:0] row_start;
    logic [15:0] row_end;

    modport ser (output unit_valid, output unit_dc, output unit_byte,
                 input rd_len, input rd_word);
    modport pix (input col_start, input col_end, input row_start,
                 input row_end);
    modport core (input unit_valid, input unit_dc, input unit_byte,
                  output rd_len, output rd_word, output col_start,
                  output col_end, output row_start, output row_end);
endinterface

// >>> lsr_serial.sv
// Three-wire serial engine: unit capture and read-back shifting.
`timescale 1ns/100ps
module lsr_serial
    import lsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    lsr_if.ser link
);
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [2:0] sdi_sync;
    lsr_ser_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [31:0] out_word;
    logic [5:0] out_left;

    // Pins pass two stages; the third stage marks the level before an edge.
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_sync <= '1;
            sck_sync <= '0;
            sdi_sync <= '0;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_select_n};
            sck_sync <= {sck_sync[1:0], serial_clock};
            sdi_sync <= {sdi_sync[1:0], serial_data_in};
        end
    end

    wire logic cs_idle = cs_sync[1];
    wire logic cs_fall = cs_sync[2] & ~cs_sync[1];
    wire logic sck_rise = sck_sync[1] & ~sck_sync[2];
    wire logic sck_fall = ~sck_sync[1] & sck_sync[2];
    wire logic sdi_bit = sdi_sync[2];
    wire logic start_read = link.unit_valid & ~link.unit_dc &
                            (link.rd_len != LSR_LEN_NONE);

    always_ff @(posedge clk) begin
        link.unit_valid <= 1'b0;
        if (reset || cs_idle) begin
            state <= LSR_SER_IDLE;
            bit_cnt <= '0;
            shreg <= '0;
            serial_data_oe <= 1'b0;
            serial_data_out <= 1'b0;
            out_left <= LSR_LEN_NONE;
            out_word <= '0;
            if (reset) begin
                link.unit_dc <= 1'b0;
                link.unit_byte <= '0;
            end
        end else begin
            case (state)
                LSR_SER_IDLE: begin
                    if (cs_fall) begin
                        state <= LSR_SER_SHIFT;
                        bit_cnt <= '0;
                    end
                end
                LSR_SER_SHIFT: begin
                    if (sck_rise) begin
                        shreg <= {shreg[6:0], sdi_bit};
                        if (bit_cnt == LSR_UNIT_LAST) begin
                            link.unit_valid <= 1'b1;
                            link.unit_dc <= shreg[7];
                            link.unit_byte <= {shreg[6:0], sdi_bit};
                            bit_cnt <= '0;
                        end else begin
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                        end
                    end else if (start_read) begin
                        state <= LSR_SER_READ;
                        out_word <= link.rd_word;
                        out_left <= link.rd_len;
                    end
                end
                LSR_SER_READ: begin
                    if (sck_fall && out_left != LSR_LEN_NONE) begin
                        serial_data_oe <= 1'b1;
                        serial_data_out <= out_word[31];
                        out_word <= {out_word[30:0], 1'b0};
                        out_left <= 6'(out_left - 6'h01);
                    end
                end
                default: state <= LSR_SER_IDLE;
            endcase
        end
    end

    property p_cs_idle;
        @(posedge clk) disable iff (reset)
        cs_sync[1] |=> state == LSR_SER_IDLE && !serial_data_oe;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("serial engine active while chip select high");

    property p_sdo_fall;
        @(posedge clk) disable iff (reset)
        $rose(serial_data_oe) || (serial_data_oe && $changed(serial_data_out))
            |-> $past(sck_fall);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall)
        else $error("read data changed away from a falling clock edge");

    property p_sample_rise;
        @(posedge clk) disable iff (reset)
        link.unit_valid |-> $past(sck_rise) && $past(state) == LSR_SER_SHIFT;
    endproperty
    a_sample_rise: assert property (p_sample_rise)
        else $error("unit completed without a rising clock edge");

    c_read_bit: cover property (@(posedge clk) disable iff (reset)
        state == LSR_SER_READ && sck_fall);
endmodule

// >>> lsr_pixel.sv
// Parallel pixel engine: sync tracking and window addressing.
`timescale 1ns/100ps
module lsr_pixel
    import lsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic pixel_clock,
    input wire logic frame_sync_n,
    input wire logic line_sync_n,
    input wire logic pixel_data_valid,
    input wire logic [LSR_PIXEL_BITS-1:0] pixel_data,
    lsr_if.pix win,
    output logic pix_we,
    output logic [LSR_ADDR_BITS-1:0] pix_col,
    output logic [LSR_ADDR_BITS-1:0] pix_row,
    output logic [LSR_PIXEL_BITS-1:0] pix_data,
    output logic frame_start
);
    logic [3:0] ctl_s1;
    logic [3:0] ctl_s2;
    logic [3:0] ctl_s3;
    logic [LSR_PIXEL_BITS-1:0] dat_s1;
    logic [LSR_PIXEL_BITS-1:0] dat_s2;
    logic [LSR_PIXEL_BITS-1:0] dat_s3;
    lsr_pix_state_type state;
    logic [LSR_ADDR_BITS-1:0] col;
    logic [LSR_ADDR_BITS-1:0] row;

    // Bit order: pixel clock, frame sync, line sync, data valid.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_s1 <= 4'h6;
            ctl_s2 <= 4'h6;
            ctl_s3 <= 4'h6;
            dat_s1 <= '0;
            dat_s2 <= '0;
            dat_s3 <= '0;
        end else begin
            ctl_s1 <= {pixel_clock, frame_sync_n, line_sync_n,
                       pixel_data_valid};
            ctl_s2 <= ctl_s1;
            ctl_s3 <= ctl_s2;
            dat_s1 <= pixel_data;
            dat_s2 <= dat_s1;
            dat_s3 <= dat_s2;
        end
    end

    wire logic dclk_rise = ctl_s2[3] & ~ctl_s3[3];
    wire logic frame_fall = ctl_s3[2] & ~ctl_s2[2];
    wire logic line_run = ctl_s3[2] & ctl_s3[1];
    wire logic take = dclk_rise & line_run & ctl_s3[0] &
                      (state == LSR_PIX_DRAW);
    wire logic line_end = (col == win.col_end);
    wire logic frame_end = line_end & (row == win.row_end);

    always_ff @(posedge clk) begin
        pix_we <= 1'b0;
        frame_start <= 1'b0;
        if (reset) begin
            state <= LSR_PIX_PORCH;
            col <= '0;
            row <= '0;
            pix_col <= '0;
            pix_row <= '0;
            pix_data <= '0;
        end else if (frame_fall) begin
            state <= LSR_PIX_DRAW;
            col <= win.col_start;
            row <= win.row_start;
            frame_start <= 1'b1;
        end else if (take) begin
            pix_we <= 1'b1;
            pix_col <= col;
            pix_row <= row;
            pix_data <= dat_s3;
            col <= line_end ? win.col_start : 16'(col + 16'h0001);
            if (frame_end) begin
                state <= LSR_PIX_PORCH;
            end else if (line_end) begin
                row <= 16'(row + 16'h0001);
            end
        end
    end

    property p_frame_reload;
        @(posedge clk) disable iff (reset)
        frame_fall |=> col == $past(win.col_start) &&
                       row == $past(win.row_start) && frame_start;
    endproperty
    a_frame_reload: assert property (p_frame_reload)
        else $error("address not reloaded at frame sync fall");

    property p_porch_hold;
        @(posedge clk) disable iff (reset)
        state == LSR_PIX_PORCH && !frame_fall |=>
            state == LSR_PIX_PORCH && !pix_we;
    endproperty
    a_porch_hold: assert property (p_porch_hold)
        else $error("left front porch without frame sync");

    property p_write_cause;
        @(posedge clk) disable iff (reset)
        pix_we |-> $past(ctl_s3[0]) && $past(dclk_rise) && $past(line_run);
    endproperty
    a_write_cause: assert property (p_write_cause)
        else $error("pixel written without valid data");

    c_frame_done: cover property (@(posedge clk) disable iff (reset)
        take && frame_end);
endmodule

// >>> lsr_top.sv
// Display input logic: serial command port and parallel pixel port.
//
// Behaviour
// - Unit is select bit plus one byte.
// - Select bit zero marks a command opcode.
// - Select bit one marks data or parameter.
// - Commands in any order, bytes MSB first.
// - Chip select high keeps the port idle.
// - Chip select falling edge starts a transfer.
// - Read command is followed by returned bytes.
// - Input data sampled on serial clock rising.
// - Read data changes on serial clock falling.
// - Identity and status reads return eight bits.
// - Display identification read returns 24 bits.
// - Display state read returns 32 bits.
// - Pixel carries six bits per colour.
// - Pixel port follows syncs and pixel clock.
// - Pixels land only inside the window.
// - Porch timing must match on both sides.
// - Syncs active low, data needs valid high.
// - Frame sync fall reloads the address counter.
// - Stay in front porch until frame sync.
`timescale 1ns/100ps
module lsr_top
    import lsr_pkg::*;
#(
    parameter logic [7:0] OP_ID_ONE = 8'hd1,
    parameter logic [7:0] OP_ID_TWO = 8'hd2,
    parameter logic [7:0] OP_ID_THREE = 8'hd3,
    parameter logic [7:0] OP_IDENT = 8'h01,
    parameter logic [7:0] OP_STATE = 8'h02,
    parameter logic [7:0] OP_COL_WINDOW = 8'h21,
    parameter logic [7:0] OP_ROW_WINDOW = 8'h22,
    parameter logic [7:0] OP_MEM_WRITE = 8'h23
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hw_reset_n,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic pixel_clock,
    input wire logic frame_sync_n,
    input wire logic line_sync_n,
    input wire logic pixel_data_valid,
    input wire logic [LSR_PIXEL_BITS-1:0] pixel_data,
    input wire logic [23:0] id_bytes,
    input wire logic [47:0] status_bytes,
    input wire logic [23:0] display_ident,
    input wire logic [31:0] display_state,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic param_valid,
    output logic [7:0] param_index,
    output logic [7:0] param_byte,
    output logic display_byte_valid,
    output logic [7:0] display_byte,
    output logic pix_we,
    output logic [LSR_ADDR_BITS-1:0] pix_col,
    output logic [LSR_ADDR_BITS-1:0] pix_row,
    output logic [LSR_PIXEL_BITS-1:0] pix_data,
    output logic frame_start
);
    logic [1:0] hw_sync;
    logic rst;
    logic [7:0] cur_op;
    logic [7:0] param_cnt;
    logic [15:0] col_start;
    logic [15:0] col_end;
    logic [15:0] row_start;
    logic [15:0] row_end;

    lsr_if link ();

    // The hardware reset pin is synchronised and joins the system reset.
    always_ff @(posedge clk) begin
        if (reset) begin
            hw_sync <= '0;
        end else begin
            hw_sync <= {hw_sync[0], hw_reset_n};
        end
    end
    assign rst = reset | ~hw_sync[1];

    lsr_serial u_serial (
        .clk(clk),
        .reset(rst),
        .chip_select_n(chip_select_n),
        .serial_clock(serial_clock),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe),
        .link(link.ser)
    );

    lsr_pixel u_pixel (
        .clk(clk),
        .reset(rst),
        .pixel_clock(pixel_clock),
        .frame_sync_n(frame_sync_n),
        .line_sync_n(line_sync_n),
        .pixel_data_valid(pixel_data_valid),
        .pixel_data(pixel_data),
        .win(link.pix),
        .pix_we(pix_we),
        .pix_col(pix_col),
        .pix_row(pix_row),
        .pix_data(pix_data),
        .frame_start(frame_start)
    );

    // Unit decoding and read-back selection.
    wire logic is_cmd = link.unit_valid & ~link.unit_dc;
    wire logic is_data = link.unit_valid & link.unit_dc;
    wire logic [7:0] op = link.unit_byte;
    wire logic op_id1 = (op == OP_ID_ONE);
    wire logic op_id2 = (op == OP_ID_TWO);
    wire logic op_id3 = (op == OP_ID_THREE);
    wire logic op_status = lsr_in_range({8'h00, op},
                                        {8'h00, LSR_STATUS_FIRST},
                                        {8'h00, LSR_STATUS_LAST});
    wire logic op_ident = (op == OP_IDENT);
    wire logic op_state = (op == OP_STATE);
    wire logic op_byte = op_id1 | op_id2 | op_id3 | op_status;
    wire logic [2:0] status_sel = 3'(op - LSR_STATUS_FIRST);
    wire logic [7:0] status_byte = status_bytes[8 * status_sel +: 8];
    wire logic [7:0] id_byte = op_id1 ? id_bytes[23:16] :
                               op_id2 ? id_bytes[15:8] : id_bytes[7:0];
    wire logic [7:0] byte_answer = op_status ? status_byte : id_byte;
    wire logic in_mem_write = (cur_op == OP_MEM_WRITE);
    wire logic in_col = (cur_op == OP_COL_WINDOW);
    wire logic in_row = (cur_op == OP_ROW_WINDOW);
    wire logic [1:0] win_idx = param_cnt[1:0];
    wire logic win_slot = (param_cnt <= {6'h00, LSR_WIN_END_LO});

    assign link.rd_len = !is_cmd ? LSR_LEN_NONE :
                         op_byte ? LSR_LEN_BYTE :
                         op_ident ? LSR_LEN_IDENT :
                         op_state ? LSR_LEN_STATE :
                         LSR_LEN_NONE;
    assign link.rd_word = op_byte ? {byte_answer, {24{1'b0}}} :
                          op_ident ? {display_ident, {8{1'b0}}} :
                          display_state;
    assign link.col_start = col_start;
    assign link.col_end = col_end;
    assign link.row_start = row_start;
    assign link.row_end = row_end;

    // Command and parameter tracking; any opcode may follow any other.
    always_ff @(posedge clk) begin
        cmd_valid <= 1'b0;
        param_valid <= 1'b0;
        display_byte_valid <= 1'b0;
        if (rst) begin
            cmd_opcode <= '0;
            cur_op <= '0;
            param_cnt <= '0;
            param_index <= '0;
            param_byte <= '0;
            display_byte <= '0;
        end else if (is_cmd) begin
            cmd_valid <= 1'b1;
            cmd_opcode <= op;
            cur_op <= op;
            param_cnt <= '0;
        end else if (is_data && in_mem_write) begin
            display_byte_valid <= 1'b1;
            display_byte <= op;
        end else if (is_data) begin
            param_valid <= 1'b1;
            param_index <= param_cnt;
            param_byte <= op;
            if (param_cnt != 8'hff) begin
                param_cnt <= 8'(param_cnt + 8'h01);
            end
        end
    end

    // Window bounds, written high byte first by the window commands.
    always_ff @(posedge clk) begin
        if (rst) begin
            col_start <= LSR_WIN_MIN;
            col_end <= LSR_WIN_MAX;
            row_start <= LSR_WIN_MIN;
            row_end <= LSR_WIN_MAX;
        end else if (is_data && win_slot && (in_col || in_row)) begin
            case (win_idx)
                LSR_WIN_START_HI: begin
                    if (in_col) col_start[15:8] <= op;
                    else row_start[15:8] <= op;
                end
                LSR_WIN_START_LO: begin
                    if (in_col) col_start[7:0] <= op;
                    else row_start[7:0] <= op;
                end
                LSR_WIN_END_HI: begin
                    if (in_col) col_end[15:8] <= op;
                    else row_end[15:8] <= op;
                end
                LSR_WIN_END_LO: begin
                    if (in_col) col_end[7:0] <= op;
                    else row_end[7:0] <= op;
                end
                default: begin
                    col_start <= col_start;
                end
            endcase
        end
    end

    property p_cmd_decode;
        @(posedge clk) disable iff (rst)
        is_cmd |=> cmd_valid && cmd_opcode == $past(op) && !param_valid;
    endproperty
    a_cmd_decode: assert property (p_cmd_decode)
        else $error("command unit not reported as opcode");

    property p_param_store;
        @(posedge clk) disable iff (rst)
        is_data && !in_mem_write |=>
            param_valid && param_byte == $past(op) && !cmd_valid;
    endproperty
    a_param_store: assert property (p_param_store)
        else $error("data unit not stored as parameter");

    property p_display_data;
        @(posedge clk) disable iff (rst)
        is_data && in_mem_write |=>
            display_byte_valid && display_byte == $past(op);
    endproperty
    a_display_data: assert property (p_display_data)
        else $error("display data byte lost");

    property p_read_byte;
        @(posedge clk) disable iff (rst)
        is_cmd && op_byte |-> link.rd_len == LSR_LEN_BYTE &&
            link.rd_word[31:24] == byte_answer;
    endproperty
    a_read_byte: assert property (p_read_byte)
        else $error("byte read has wrong length");

    property p_read_ident;
        @(posedge clk) disable iff (rst)
        is_cmd && op_ident |-> link.rd_len == LSR_LEN_IDENT &&
            link.rd_word[31:8] == display_ident;
    endproperty
    a_read_ident: assert property (p_read_ident)
        else $error("identification read has wrong length");

    property p_read_state;
        @(posedge clk) disable iff (rst)
        is_cmd && op_state |-> link.rd_len == LSR_LEN_STATE &&
            link.rd_word == display_state;
    endproperty
    a_read_state: assert property (p_read_state)
        else $error("state read has wrong length");

    property p_window_only;
        @(posedge clk) disable iff (rst)
        pix_we |-> lsr_in_range(pix_col, col_start, col_end) &&
                   lsr_in_range(pix_row, row_start, row_end);
    endproperty
    a_window_only: assert property (p_window_only)
        else $error("pixel written outside the window");

    property p_no_oe_idle;
        @(posedge clk) disable iff (rst)
        $fell(serial_data_oe) |-> $past(chip_select_n, 3);
    endproperty
    a_no_oe_idle: assert property (p_no_oe_idle)
        else $error("read drive dropped while selected");

    c_state_read: cover property (@(posedge clk) disable iff (rst)
        is_cmd && op_state);
    c_display_byte: cover property (@(posedge clk) disable iff (rst)
        display_byte_valid);
    c_pixel: cover property (@(posedge clk) disable iff (rst) pix_we);
endmodule

// >>> lsr_host.sv
// Host display controller model for the serial and pixel ports.
`timescale 1ns/100ps
module lsr_host
    import lsr_pkg::*;
(
    input wire logic clk,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_data_in,
    output logic pixel_clock,
    output logic frame_sync_n,
    output logic line_sync_n,
    output logic pixel_data_valid,
    output logic [LSR_PIXEL_BITS-1:0] pixel_data
);
    logic drv = 1'b1;
    logic host_oe = 1'b1;
    initial begin
        {chip_select_n, frame_sync_n, line_sync_n} = 3'h7;
        {serial_clock, pixel_clock, pixel_data_valid} = 3'h0;
        pixel_data = '0;
    end
    // A released line shows the inverse of the last driven value.
    assign serial_data_in = serial_data_oe ? serial_data_out : drv ^ !host_oe;
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic sel(input logic on);
        wt(4);
        chip_select_n = !on;
        wt(8);
        host_oe = 1'b1;
    endtask
    task automatic sbit(input logic d, input logic rel, output logic q);
        host_oe = !rel;
        drv = rel ? drv : d;
        wt(4);
        serial_clock = 1'b1;
        wt(2);
        q = serial_data_in;
        wt(2);
        serial_clock = 1'b0;
    endtask
    task automatic unit(input logic dc, input logic [7:0] b);
        logic q;
        sbit(dc, 1'b0, q);
        for (int i = 7; i >= 0; i--) sbit(b[i], 1'b0, q);
    endtask
    task automatic rd(input int n, output logic [31:0] w);
        logic q;
        w = '0;
        for (int i = 0; i < n; i++) begin
            sbit(1'b0, 1'b1, q);
            w = {w[30:0], q};
        end
    endtask
    task automatic pix(input logic v, input logic [17:0] d);
        pixel_data_valid = v;
        pixel_data = d;
        wt(4);
        pixel_clock = 1'b1;
        wt(4);
        pixel_clock = 1'b0;
    endtask
    task automatic line;
        repeat (2) pix(1'b0, '0);
        line_sync_n = 1'b0;
        repeat (40) pix(1'b0, '0);
        line_sync_n = 1'b1;
        repeat (40) pix(1'b0, '0);
    endtask
    task automatic frame;
        repeat (2) line;
        frame_sync_n = 1'b0;
        repeat (2) line;
        frame_sync_n = 1'b1;
        repeat (2) line;
    endtask
endmodule

// >>> tb_top.sv
// Testbench for the serial command and pixel input block.
`timescale 1ns/100ps
module tb_top;
    import lsr_pkg::*;
    logic clk, serial_data_out, serial_data_oe, chip_select_n, serial_clock;
    logic reset = 1'b1, hw_reset_n = 1'b1;
    logic serial_data_in, pixel_clock, frame_sync_n, line_sync_n, pix_we;
    logic pixel_data_valid, cmd_valid, param_valid, frame_start;
    logic display_byte_valid;
    logic [LSR_PIXEL_BITS-1:0] pixel_data, pix_data;
    logic [7:0] cmd_opcode, param_index, param_byte, lcmd;
    logic [7:0] display_byte, ldisp;
    logic [15:0] pix_col, pix_row, lpar;
    logic [23:0] id_bytes = 24'h5ac396, display_ident = 24'h123456;
    logic [47:0] status_bytes = 48'he70000000011;
    logic [31:0] w, display_state = 32'h89abcdef;
    logic [49:0] pq[$];
    int num_errors = 0, compares = 0, ncmd = 0, nframe = 0, n0;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    lsr_host u_lsr_host (.clk(clk), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .pixel_clock(pixel_clock), .frame_sync_n(frame_sync_n),
        .line_sync_n(line_sync_n), .pixel_data_valid(pixel_data_valid),
        .pixel_data(pixel_data));
    lsr_top u_lsr_top (.clk(clk), .reset(reset), .hw_reset_n(hw_reset_n),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .pixel_clock(pixel_clock),
        .frame_sync_n(frame_sync_n), .line_sync_n(line_sync_n),
        .pixel_data_valid(pixel_data_valid), .pixel_data(pixel_data),
        .id_bytes(id_bytes), .status_bytes(status_bytes),
        .display_ident(display_ident), .display_state(display_state),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .param_valid(param_valid), .param_index(param_index),
        .param_byte(param_byte), .display_byte_valid(display_byte_valid),
        .display_byte(display_byte), .pix_we(pix_we), .pix_col(pix_col),
        .pix_row(pix_row), .pix_data(pix_data), .frame_start(frame_start));
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) {ncmd, lcmd} = {ncmd + 1, cmd_opcode};
        if (param_valid === 1'b1) lpar = {param_index, param_byte};
        if (display_byte_valid === 1'b1) ldisp = display_byte;
        if (pix_we === 1'b1) pq.push_back({pix_col, pix_row, pix_data});
        if (frame_start === 1'b1) nframe++;
    end
    task automatic chk(input logic [49:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s", $time, m);
            num_errors++;
        end
    endtask
    task automatic results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_write;
        n0 = ncmd;
        u_lsr_host.sel(1'b1);
        u_lsr_host.unit(1'b0, 8'h3c);
        u_lsr_host.unit(1'b1, 8'h81);
        u_lsr_host.unit(1'b1, 8'h7e);
        u_lsr_host.sel(1'b0);
        chk(lcmd, 8'h3c, "opcode");
        chk(ncmd, n0 + 1, "command count");
        chk(lpar, 16'h017e, "parameter");
        u_lsr_host.unit(1'b0, 8'h5c);
        chk(ncmd, n0 + 1, "unselected unit");
    endtask
    task automatic t_read(input logic [7:0] op, input int n, logic [31:0] e);
        u_lsr_host.sel(1'b1);
        u_lsr_host.unit(1'b0, op);
        u_lsr_host.rd(n, w);
        u_lsr_host.sel(1'b0);
        chk(w, e, "read value");
        chk(serial_data_oe, 1'b0, "line released");
    endtask
    task automatic t_pixel;
        logic [7:0] s[12] = '{8'h21, 0, 0, 0, 1, 8'h22, 0, 0, 0, 0, 8'h23,
                              8'hc5};
        u_lsr_host.sel(1'b1);
        foreach (s[i]) u_lsr_host.unit(i % 5 != 0, s[i]);
        u_lsr_host.sel(1'b0);
        chk(ldisp, 8'hc5, "display byte");
        n0 = nframe;
        u_lsr_host.frame;
        chk(nframe, n0 + 1, "frame start");
        pq.delete();
        u_lsr_host.pix(1'b0, 18'h3ffff);
        u_lsr_host.pix(1'b1, 18'h2a015);
        u_lsr_host.pix(1'b1, 18'h15a3c);
        u_lsr_host.pix(1'b1, 18'h3f000);
        u_lsr_host.wt(8);
        chk(pq.size(), 2, "write count");
        chk(pq[0], {32'h0, 18'h2a015}, "first pixel");
        chk(pq[1], {16'h1, 16'h0, 18'h15a3c}, "second pixel");
        u_lsr_host.frame;
        u_lsr_host.pix(1'b1, 18'h00fff);
        u_lsr_host.wt(8);
        chk(pq[2], {32'h0, 18'h00fff}, "reloaded address");
    endtask
    task automatic t_hw_reset;
        hw_reset_n = 1'b0;
        u_lsr_host.wt(8);
        hw_reset_n = 1'b1;
        u_lsr_host.frame;
        pq.delete();
        repeat (3) u_lsr_host.pix(1'b1, 18'h0abcd);
        u_lsr_host.wt(8);
        chk(pq[2], {16'h2, 16'h0, 18'h0abcd}, "full window");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        u_lsr_host.wt(4);
        t_write;
        t_read(8'hd1, 8, 32'h5a);
        t_read(8'h0f, 8, 32'he7);
        t_read(8'h01, 24, 32'h123456);
        t_read(8'h02, 32, 32'h89abcdef);
        t_pixel;
        t_hw_reset;
        results;
    end
    initial begin
        #500000;
        num_errors++;
        results;
    end
endmodule
